// >>> shared/regstate_pkg.sv
// Purpose: Shared constants and types for the banked register state block
// Assumes: 32-bit data path, five-bit mode field
// Notes: Mode codes, physical register indices and status bit positions
package regstate_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_PHYS = 31;
  localparam int unsigned NUM_SAVED = 5;

  // Mode field codes
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1B;
  localparam logic [4:0] MODE_SYS = 5'h1F;

  // Status register bit positions
  localparam int unsigned PSR_STATE_BIT = 5;
  localparam int unsigned PSR_MODE_LSB = 0;
  localparam int unsigned PSR_MODE_MSB = 4;

  // Architectural register numbers
  localparam logic [3:0] REG_FIQ_FIRST = 4'h8;
  localparam logic [3:0] REG_SP = 4'hD;
  localparam logic [3:0] REG_LR = 4'hE;
  localparam logic [3:0] REG_PC = 4'hF;

  // Physical index bases for banked copies
  localparam logic [4:0] PHYS_FIQ_BASE = 5'h0F;
  localparam logic [4:0] PHYS_SVC_BASE = 5'h16;
  localparam logic [4:0] PHYS_ABT_BASE = 5'h18;
  localparam logic [4:0] PHYS_IRQ_BASE = 5'h1A;
  localparam logic [4:0] PHYS_UND_BASE = 5'h1C;

  // Saved status slot numbers
  localparam logic [2:0] SAVED_FIQ = 3'h0;
  localparam logic [2:0] SAVED_SVC = 3'h1;
  localparam logic [2:0] SAVED_ABT = 3'h2;
  localparam logic [2:0] SAVED_IRQ = 3'h3;
  localparam logic [2:0] SAVED_UND = 3'h4;
  localparam logic [2:0] SAVED_NONE = 3'h7;

  // Reset values
  localparam logic [31:0] PSR_RESET = 32'h000000D3;
  localparam logic [31:0] PC_RESET = 32'h00000000;

  // Program counter low bit masks
  localparam logic [31:0] PC_WIDE_MASK = 32'hFFFFFFFC;
  localparam logic [31:0] PC_COMPACT_MASK = 32'hFFFFFFFE;
  localparam logic [31:0] PC_STEP_WIDE = 32'h00000004;
  localparam logic [31:0] PC_STEP_COMPACT = 32'h00000002;

  // Access sizes
  typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} size_t;

  // Control requests from the core's sequencer
  typedef struct packed {
    logic wr_en;             // General register write
    logic [3:0] wr_idx;      // Architectural register number
    logic [31:0] wr_data;    // Value to write
    logic bx_en;             // Branch-exchange
    logic [31:0] bx_target;  // Operand register value
    logic bl_en;             // Branch-with-link
    logic [31:0] bl_target;  // Branch destination
    logic exc_en;            // Exception entry
    logic [4:0] exc_mode;    // Mode of the exception
    logic [31:0] exc_vector; // Vector address
    logic [31:0] exc_ret;    // Return address for the link register
    logic ret_en;            // Exception return (saved to current)
    logic [31:0] ret_pc;     // Resume address
    logic psr_wr_en;         // Software write of current status
    logic [31:0] psr_wr_data;
    logic pc_step;           // Advance to next instruction
  } core_req_t;

  // Memory data lane request
  typedef struct packed {
    logic [1:0] addr_lo;     // Byte address bits
    size_t size;             // Access size
    logic [31:0] wdata;      // Right-aligned store data
    logic [31:0] bus_rdata;  // Word from data lines
  } lane_req_t;

endpackage

// >>> src/banked_register_state_control.sv
// Purpose: Banked register file, instruction state and byte lane mapping
// Assumes: Core sequencer issues one request set per cycle on clock
// Notes: Fast clock domain only reported; core logic runs on clock
// Notes on behaviour
// - Two states: 32-bit wide, 16-bit compact
// - Compact state uses PC bit 1 for halfword
// - State switch keeps mode and registers
// - Branch-exchange bit 0 selects new state
// - Exception return restores compact state if saved
// - Exception entry: wide state, link, vector
// - Byte, halfword, word; aligned halves, words
// - Seven modes; all but user privileged
// - Mode changes by software or exceptions
// - Big-endian byte 0 on lines 31:24
// - Little-endian byte 0 on lines 7:0
// - Control bit picks endianness; output follows
// - 31 general plus six status registers
// - Wide state sees 16 registers, banked swap
// - Fast interrupt banks registers 8 to 14
// - Four modes bank registers 13 and 14
// - Branch-with-link copies next PC to register 14
// - PC low bits zero per state
// - Compact state sees low eight plus SP/LR/PC; read and write ports here reach all 16
// - State output high in compact state
// - User-mode output low in user mode
// - Clock-mode select picks single or fastbus
// - Five-bit mode encodings; others illegal
// - Status state bit mirrors on state output
`timescale 1ns/1ps
`default_nettype none

module banked_register_state_control
  import regstate_pkg::*;
#(
  parameter int unsigned NPHYS = NUM_PHYS,  // General register count
  parameter int unsigned NSAVED = NUM_SAVED // Saved status count
)(
  input wire logic clock,                   // Core clock
  input wire logic srst,                    // Synchronous reset
  input wire core_req_t req,                // Sequencer requests
  input wire logic [3:0] rd_idx_a,          // Read port A register
  input wire logic [3:0] rd_idx_b,          // Read port B register
  input wire lane_req_t lane,               // Data lane request
  input wire logic big_endian_ctrl,         // Control register bit
  input wire logic fastbus_sel,             // Clocking mode pin
  output logic [31:0] rd_data_a,            // Read port A data
  output logic [31:0] rd_data_b,            // Read port B data
  output logic [31:0] pc_out,               // Fetch address
  output logic fetch_upper_half,            // Halfword select
  output logic [31:0] status_out,           // Current status
  output logic [31:0] saved_out,            // Saved status of mode
  output logic [31:0] bus_wdata,            // Lane-mapped store
  output logic [31:0] load_data,            // Aligned load value
  output logic align_fault,                 // Misaligned access
  output logic mode_illegal,                // Illegal mode field
  output logic big_endian_out,              // Byte order pin
  output logic compact_state_out,           // State pin
  output logic unprivileged_mode_n,         // User mode pin, low
  output logic fastbus_active               // Two-clock operation
);

  ////////////////////////////////////////////////////////////////////////
  // State record

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] psr;
    logic [31:0] rda;
    logic [31:0] rdb;
    logic [31:0] saved_status_reg;
    logic [31:0] wdata;
    logic [31:0] ldata;
    logic afault;
    logic illegal;
    logic bigend;
    logic fetch_hi;
    logic user_n;
    logic fast;
    logic fast_meta;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  logic [31:0] gpr_ff [NPHYS];
  logic [31:0] saved_ff [NSAVED];
  logic gpr_we;
  logic [4:0] gpr_widx;
  logic [31:0] gpr_wval;
  logic saved_status_reg_we;
  logic [2:0] saved_status_reg_widx;
  logic [31:0] saved_status_reg_wval;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Physical slot for a register number in a mode
  function automatic logic [4:0] phys_idx(input logic [4:0] m,
                                          input logic [3:0] r);
    logic [4:0] p;
    p = {1'b0, r};
    if (m == MODE_FIQ && r >= REG_FIQ_FIRST && r <= REG_LR)
      p = PHYS_FIQ_BASE + 5'(r - REG_FIQ_FIRST);
    else if (r == REG_SP || r == REG_LR)
    begin
      unique case (m)
        MODE_SVC: p = PHYS_SVC_BASE + 5'(r - REG_SP);
        MODE_ABT: p = PHYS_ABT_BASE + 5'(r - REG_SP);
        MODE_IRQ: p = PHYS_IRQ_BASE + 5'(r - REG_SP);
        MODE_UND: p = PHYS_UND_BASE + 5'(r - REG_SP);
        default: p = {1'b0, r};
      endcase
    end
    return p;
  endfunction

  // Saved status slot for a mode
  function automatic logic [2:0] saved_idx(input logic [4:0] m);
    logic [2:0] s;
    unique case (m)
      MODE_FIQ: s = SAVED_FIQ;
      MODE_SVC: s = SAVED_SVC;
      MODE_ABT: s = SAVED_ABT;
      MODE_IRQ: s = SAVED_IRQ;
      MODE_UND: s = SAVED_UND;
      default: s = SAVED_NONE;
    endcase
    return s;
  endfunction

  // Mode field is one of the seven codes
  function automatic logic mode_ok(input logic [4:0] m);
    return m == MODE_USR || m == MODE_FIQ || m == MODE_IRQ ||
           m == MODE_SVC || m == MODE_ABT || m == MODE_UND ||
           m == MODE_SYS;
  endfunction

  // Read one register as seen in the current mode and state
  function automatic logic [31:0] read_reg(input logic [4:0] m,
                                           input logic t,
                                           input logic [31:0] pc,
                                           input logic [3:0] r);
    logic [31:0] v;
    logic [4:0] p;
    p = phys_idx(m, r);
    v = gpr_ff[p];
    if (r == REG_PC)
      v = pc & (t ? PC_COMPACT_MASK : PC_WIDE_MASK);
    return v;
  endfunction

  // Word offset of a lane in the current byte order
  function automatic logic [4:0] lane_shift(input logic be,
                                            input logic [1:0] a,
                                            input size_t sz);
    logic [1:0] slot;
    slot = a;
    if (be)
    begin
      unique case (sz)
        SIZE_BYTE: slot = 2'(2'h3 - a);
        SIZE_HALF: slot = 2'(2'h2 - a);
        default: slot = 2'h0;
      endcase
    end
    return {slot, 3'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [4:0] m;
    logic t;
    logic [4:0] sh;
    logic [31:0] mask;
    logic [31:0] shifted;
    m = cur_ff.psr[PSR_MODE_MSB:PSR_MODE_LSB];
    t = cur_ff.psr[PSR_STATE_BIT];
    sh = 5'h0;
    mask = 32'h0;
    shifted = 32'h0;
    nxt_cur = cur_ff;
    gpr_we = 1'b0;
    gpr_widx = 5'h0;
    gpr_wval = 32'h0;
    saved_status_reg_we = 1'b0;
    saved_status_reg_widx = SAVED_NONE;
    saved_status_reg_wval = 32'h0;

    // Program counter and state changes, exception entry first
    if (req.exc_en)
    begin
      saved_status_reg_we = 1'b1;
      saved_status_reg_widx = saved_idx(req.exc_mode);
      saved_status_reg_wval = cur_ff.psr;
      gpr_we = 1'b1;
      gpr_widx = phys_idx(req.exc_mode, REG_LR);
      gpr_wval = req.exc_ret;
      nxt_cur.psr[PSR_MODE_MSB:PSR_MODE_LSB] = req.exc_mode;
      nxt_cur.psr[PSR_STATE_BIT] = 1'b0;
      nxt_cur.pc = req.exc_vector & PC_WIDE_MASK;
    end
    else if (req.ret_en)
    begin
      // Restores state bit from the saved copy
      nxt_cur.psr = saved_ff[saved_idx(m)];
      nxt_cur.pc = req.ret_pc & (saved_ff[saved_idx(m)][PSR_STATE_BIT]
                   ? PC_COMPACT_MASK : PC_WIDE_MASK);
    end
    else if (req.bx_en)
    begin
      // Only the state bit and PC move; mode and registers stay
      nxt_cur.psr[PSR_STATE_BIT] = req.bx_target[0];
      nxt_cur.pc = req.bx_target & (req.bx_target[0]
                   ? PC_COMPACT_MASK : PC_WIDE_MASK);
    end
    else if (req.bl_en)
    begin
      gpr_we = 1'b1;
      gpr_widx = phys_idx(m, REG_LR);
      gpr_wval = cur_ff.pc + (t ? PC_STEP_COMPACT : PC_STEP_WIDE);
      nxt_cur.pc = req.bl_target & (t ? PC_COMPACT_MASK : PC_WIDE_MASK);
    end
    else
    begin
      if (req.psr_wr_en && m != MODE_USR)
        nxt_cur.psr = req.psr_wr_data;
      else if (req.psr_wr_en)
        nxt_cur.psr[31:PSR_STATE_BIT + 3] =
          req.psr_wr_data[31:PSR_STATE_BIT + 3];
      if (req.wr_en && req.wr_idx == REG_PC)
        nxt_cur.pc = req.wr_data & (t ? PC_COMPACT_MASK : PC_WIDE_MASK);
      else if (req.pc_step)
        nxt_cur.pc = cur_ff.pc + (t ? PC_STEP_COMPACT : PC_STEP_WIDE);
      if (req.wr_en && req.wr_idx != REG_PC)
      begin
        gpr_we = 1'b1;
        gpr_widx = phys_idx(m, req.wr_idx);
        gpr_wval = req.wr_data;
      end
    end

    // Register read ports in the visible bank
    nxt_cur.rda = read_reg(m, t, cur_ff.pc, rd_idx_a);
    nxt_cur.rdb = read_reg(m, t, cur_ff.pc, rd_idx_b);
    nxt_cur.saved_status_reg = (saved_idx(m) == SAVED_NONE) ? 32'h0
                   : saved_ff[saved_idx(m)];

    // Byte lanes and alignment check
    sh = lane_shift(big_endian_ctrl, lane.addr_lo, lane.size);
    unique case (lane.size)
      SIZE_BYTE: mask = 32'h000000FF;
      SIZE_HALF: mask = 32'h0000FFFF;
      default: mask = 32'hFFFFFFFF;
    endcase
    nxt_cur.wdata = (lane.wdata & mask) << sh;
    shifted = lane.bus_rdata >> sh;
    nxt_cur.ldata = shifted & mask;
    nxt_cur.afault = (lane.size == SIZE_HALF && lane.addr_lo[0]) ||
                     (lane.size == SIZE_WORD && lane.addr_lo != 2'h0);

    // Pin outputs
    nxt_cur.illegal = !mode_ok(nxt_cur.psr[PSR_MODE_MSB:PSR_MODE_LSB]);
    nxt_cur.bigend = big_endian_ctrl;
    nxt_cur.fetch_hi = nxt_cur.psr[PSR_STATE_BIT] & nxt_cur.pc[1];
    nxt_cur.user_n =
      nxt_cur.psr[PSR_MODE_MSB:PSR_MODE_LSB] != MODE_USR;
    nxt_cur.fast_meta = fastbus_sel;
    nxt_cur.fast = cur_ff.fast_meta;

    if (srst)
    begin
      nxt_cur = '0;
      nxt_cur.psr = PSR_RESET;
      nxt_cur.pc = PC_RESET;
      nxt_cur.user_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // State record
  always_ff @(posedge clock)
  begin
    cur_ff <= nxt_cur;
  end

  // Register file: 31 general and five saved status registers
  always_ff @(posedge clock)
  begin
    if (gpr_we && !srst)
      gpr_ff[gpr_widx] <= gpr_wval;
    if (saved_status_reg_we && saved_status_reg_widx != SAVED_NONE && !srst)
      saved_ff[saved_status_reg_widx] <= saved_status_reg_wval;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data_a = cur_ff.rda;
  assign rd_data_b = cur_ff.rdb;
  assign pc_out = cur_ff.pc;
  assign fetch_upper_half = cur_ff.fetch_hi;
  assign status_out = cur_ff.psr;
  assign saved_out = cur_ff.saved_status_reg;
  assign bus_wdata = cur_ff.wdata;
  assign load_data = cur_ff.ldata;
  assign align_fault = cur_ff.afault;
  assign mode_illegal = cur_ff.illegal;
  assign big_endian_out = cur_ff.bigend;
  assign compact_state_out = cur_ff.psr[PSR_STATE_BIT];
  assign unprivileged_mode_n = cur_ff.user_n;
  assign fastbus_active = cur_ff.fast;

endmodule

`default_nettype wire

// >>> testbench/banked_register_state_control_test.sv
// Purpose: Self-checking bench for the banked register state block
// Assumes: Sequencer requests driven one cycle at a time
// Notes: Lane cases in a table, banking and states by hand
`timescale 1ns/1ps
`default_nettype none
module banked_register_state_control_test
  import regstate_pkg::*;
;
  typedef struct packed {
    logic [1:0] a;
    size_t sz;
    logic be;
    logic flt;
    logic [31:0] ld;
  } row_t;
  localparam int K_WR = 0, K_BX = 1, K_BL = 2, K_EXC = 3;
  localparam int K_RET = 4, K_PSR = 5, K_STEP = 6;
  logic clock = 1'h0;
  logic srst = 1'h1;
  core_req_t req = '0;
  logic [3:0] rd_idx_a = 4'h0;
  logic [3:0] rd_idx_b = 4'h0;
  lane_req_t lane = '0;
  logic big_endian_ctrl = 1'h0;
  logic fastbus_sel = 1'h0;
  logic [31:0] rd_data_a, rd_data_b, pc_out, status_out, saved_out;
  logic [31:0] bus_wdata, load_data;
  logic fetch_upper_half, align_fault, mode_illegal, big_endian_out;
  logic compact_state_out, unprivileged_mode_n, fastbus_active;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Load word 11223344 seen through all lanes but byte lines 23:16
  row_t rows [14] = '{
    '{2'h0, SIZE_BYTE, 1'h0, 1'h0, 32'h44}, '{2'h1, SIZE_BYTE, 1'h0, 1'h0, 32'h33},
    '{2'h3, SIZE_BYTE, 1'h0, 1'h0, 32'h11}, '{2'h0, SIZE_BYTE, 1'h1, 1'h0, 32'h11},
    '{2'h2, SIZE_BYTE, 1'h1, 1'h0, 32'h33}, '{2'h0, SIZE_HALF, 1'h0, 1'h0, 32'h3344},
    '{2'h2, SIZE_HALF, 1'h0, 1'h0, 32'h1122}, '{2'h0, SIZE_HALF, 1'h1, 1'h0, 32'h1122},
    '{2'h2, SIZE_HALF, 1'h1, 1'h0, 32'h3344}, '{2'h0, SIZE_WORD, 1'h0, 1'h0, 32'h11223344},
    '{2'h0, SIZE_WORD, 1'h1, 1'h0, 32'h11223344}, '{2'h1, SIZE_HALF, 1'h0, 1'h1, 32'h0},
    '{2'h2, SIZE_WORD, 1'h1, 1'h1, 32'h0}, '{2'h3, SIZE_HALF, 1'h1, 1'h1, 32'h0}};

  banked_register_state_control u_banked_register_state_control (
    .clock(clock), .srst(srst), .req(req), .rd_idx_a(rd_idx_a),
    .rd_idx_b(rd_idx_b), .lane(lane), .big_endian_ctrl(big_endian_ctrl),
    .fastbus_sel(fastbus_sel), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b),
    .pc_out(pc_out), .fetch_upper_half(fetch_upper_half),
    .status_out(status_out), .saved_out(saved_out), .bus_wdata(bus_wdata),
    .load_data(load_data), .align_fault(align_fault),
    .mode_illegal(mode_illegal), .big_endian_out(big_endian_out),
    .compact_state_out(compact_state_out),
    .unprivileged_mode_n(unprivileged_mode_n),
    .fastbus_active(fastbus_active));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard, shared tasks
  always #4 clock = ~clock;

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One request cycle, then idle; returns where outputs have settled
  task automatic op(input int k, input logic [31:0] a,
                    input logic [31:0] b = 32'h0, input logic [31:0] c = 32'h0);
    core_req_t r;
    r.wr_en = (k == K_WR);
    r.wr_idx = a[3:0];
    r.wr_data = b;
    r.bx_en = (k == K_BX);
    r.bx_target = a;
    r.bl_en = (k == K_BL);
    r.bl_target = a;
    r.exc_en = (k == K_EXC);
    r.exc_mode = a[4:0];
    r.exc_vector = b;
    r.exc_ret = c;
    r.ret_en = (k == K_RET);
    r.ret_pc = a;
    r.psr_wr_en = (k == K_PSR);
    r.psr_wr_data = a;
    r.pc_step = (k == K_STEP);
    @(posedge clock);
    req <= r;
    @(posedge clock);
    req <= '0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [3:0] i, input logic [31:0] exp);
    @(posedge clock);
    rd_idx_a <= i;
    rd_idx_b <= i;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(rd_data_a, exp);
    check(rd_data_b, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    srst <= 1'h0;
    @(negedge clock);
    check(status_out, PSR_RESET);
    check(32'(unprivileged_mode_n), 32'h1);
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clock);
      lane <= '{rows[i].a, rows[i].sz, 32'hA5B6C7D8, 32'h11223344};
      big_endian_ctrl <= rows[i].be;
      fastbus_sel <= i[0];
      repeat (2) @(posedge clock);
      @(negedge clock);
      check(32'(align_fault), 32'(rows[i].flt));
      if (!rows[i].flt)
        check(load_data, rows[i].ld);
    end
    @(posedge clock);
    lane <= '{2'h1, SIZE_BYTE, 32'hA5B6C7D8, 32'h11223344};
    big_endian_ctrl <= 1'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(bus_wdata, 32'h0000D800);
    op(K_WR, 32'h8, 32'h8);
    op(K_WR, 32'hD, 32'h5C);
    op(K_EXC, 32'(MODE_FIQ), 32'h1C, 32'h40);
    check(32'(status_out[5:0]), 32'(MODE_FIQ));
    check(pc_out, 32'h1C);
    op(K_WR, 32'h8, 32'hF8);
    op(K_WR, 32'hD, 32'hF13);
    rd(4'h8, 32'hF8);
    rd(4'hD, 32'hF13);
    rd(4'hE, 32'h40);
    op(K_PSR, 32'(MODE_SYS));
    check(32'(status_out[4:0]), 32'(MODE_SYS));
    check(32'(mode_illegal), 32'h0);
    rd(4'h8, 32'h8);
    op(K_WR, 32'hD, 32'h113);
    op(K_PSR, 32'(MODE_SVC));
    rd(4'hD, 32'h5C);
    op(K_PSR, 32'h15);
    check(32'(mode_illegal), 32'h1);
    op(K_PSR, 32'(MODE_SVC));
    check(32'(mode_illegal), 32'h0);
    op(K_PSR, 32'(MODE_USR));
    check(32'(unprivileged_mode_n), 32'h0);
    rd(4'hD, 32'h113);
    op(K_PSR, 32'(MODE_SVC));
    check(32'(status_out[4:0]), 32'(MODE_USR));
    op(K_BX, 32'h201);
    check(32'(compact_state_out), 32'h1);
    check(pc_out, 32'h200);
    check(32'(status_out[4:0]), 32'(MODE_USR));
    rd(4'h8, 32'h8);
    op(K_BL, 32'h300);
    rd(4'hE, 32'h202);
    op(K_STEP, 32'h0);
    check(pc_out, 32'h302);
    @(negedge clock);
    check(32'(fetch_upper_half), 32'h1);
    rd(4'hF, 32'h302);
    op(K_EXC, 32'(MODE_IRQ), 32'h18, 32'h304);
    check(32'(status_out[5:0]), 32'(MODE_IRQ));
    @(negedge clock);
    check(32'(saved_out[7:0]), 32'h30);
    op(K_RET, 32'h304);
    check(32'(compact_state_out), 32'h1);
    check(32'(status_out[4:0]), 32'(MODE_USR));
    @(posedge clock);
    srst <= 1'h1;
    repeat (2) @(posedge clock);
    srst <= 1'h0;
    @(negedge clock);
    check(status_out, PSR_RESET);
    check(pc_out, PC_RESET);
    report_and_stop();
  end
endmodule

bind banked_register_state_control regstate_monitor u_regstate_monitor (
  .clock(clock), .srst(srst), .req(req), .lane(lane),
  .big_endian_ctrl(big_endian_ctrl), .fastbus_sel(fastbus_sel),
  .pc_out(pc_out), .status_out(status_out), .align_fault(align_fault),
  .big_endian_out(big_endian_out), .compact_state_out(compact_state_out),
  .unprivileged_mode_n(unprivileged_mode_n), .fastbus_active(fastbus_active));
`default_nettype wire

// >>> testbench/regstate_monitor.sv
// Purpose: Port checker for the banked register state block
// Assumes: One clock domain, bound to the top module
// Notes: Synchronous reset disables every property
`timescale 1ns/1ps
`default_nettype none
module regstate_monitor
  import regstate_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic srst, // Sync reset
  input wire core_req_t req, // Requests
  input wire lane_req_t lane, // Lane request
  input wire logic big_endian_ctrl, // Byte order bit
  input wire logic fastbus_sel, // Clock mode pin
  input wire logic [31:0] pc_out, // Fetch address
  input wire logic [31:0] status_out, // Current status
  input wire logic align_fault, // Misaligned
  input wire logic big_endian_out, // Byte order pin
  input wire logic compact_state_out, // State pin
  input wire logic unprivileged_mode_n, // User pin
  input wire logic fastbus_active // Two-clock pin
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Steps of exception entry, of a plain state switch and of a user status write
  sequence exc_taken;
    req.exc_en;
  endsequence
  sequence at_vector;
    !compact_state_out && status_out[4:0] == $past(req.exc_mode)
      && pc_out == $past(req.exc_vector);
  endsequence
  sequence bx_only;
    req.bx_en && !req.exc_en && !req.ret_en;
  endsequence
  sequence user_psr_write;
    req.psr_wr_en && !req.exc_en && !req.ret_en && !req.bx_en
      && !req.bl_en && !unprivileged_mode_n;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Status, state and pin relations
  exc_entry_a: assert property (exc_taken |=> at_vector)
    else $error("exception entry went wrong");
  bx_switch_a: assert property (bx_only |=>
    compact_state_out == $past(req.bx_target[0])
    && status_out[4:0] == $past(status_out[4:0]))
    else $error("branch exchange state wrong");
  user_psr_a: assert property (user_psr_write |=>
    status_out[7:0] == $past(status_out[7:0]))
    else $error("user changed control bits");
  state_pin_a: assert property (compact_state_out == status_out[5])
    else $error("state pin differs from status");
  user_pin_a: assert property (
    unprivileged_mode_n == (status_out[4:0] != MODE_USR))
    else $error("user pin wrong");
  pc_wide_a: assert property (!compact_state_out |-> pc_out[1:0] == 2'h0)
    else $error("wide pc not word aligned");
  pc_half_a: assert property (compact_state_out |-> !pc_out[0])
    else $error("compact pc odd");
  endian_pin_a: assert property (!$past(srst) |->
    big_endian_out == $past(big_endian_ctrl))
    else $error("byte order pin lags");
  fastbus_sync_a: assert property (!$past(srst) && !$past(srst, 2) |->
    fastbus_active == $past(fastbus_sel, 2))
    else $error("fastbus pin wrong");
  word_align_a: assert property (
    lane.size == SIZE_WORD && lane.addr_lo != 2'h0 |=> align_fault)
    else $error("misaligned word not flagged");
  byte_align_a: assert property (lane.size == SIZE_BYTE |=> !align_fault)
    else $error("byte flagged misaligned");
endmodule
`default_nettype wire
